// ### src/cfr_dark_ref.sv
// per-line dark level averager for one output
`timescale 1ns/1ps
module cfr_dark_ref #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         acc_en,
  input  wire logic         load,
  input  wire logic [W-1:0] sample,
  output logic [W-1:0]      level,
  output logic              level_valid
);
  localparam int AW = W + cfr_pkg::DARK_AVG_SH;

  typedef struct packed {
    logic [AW-1:0] acc;
    logic [W-1:0]  lvl;
    logic          vld;
  } cfr_dark_s;

  cfr_dark_s st_r;
  cfr_dark_s st_nxt;

  assign level       = st_r.lvl;
  assign level_valid = st_r.vld;

  always_comb
  begin
    st_nxt     = st_r;
    st_nxt.vld = 1'b0;
    if (load)
    begin
      st_nxt.lvl = W'(st_r.acc >> cfr_pkg::DARK_AVG_SH);
      st_nxt.vld = 1'b1;
      st_nxt.acc = '0;
    end
    else if (acc_en)
      st_nxt.acc = st_r.acc + AW'(sample);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

endmodule : cfr_dark_ref

// ### src/cfr_fifo.sv
// pixel fifo with registered output stage
`timescale 1ns/1ps
module cfr_fifo #(
  parameter int W     = 37,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } cfr_fifo_s;

  cfr_fifo_s st_r;
  cfr_fifo_s st_nxt;
  logic      wr;
  logic      rd;

  assign in_ready  = (st_r.cnt < (AW+1)'(DEPTH));
  assign out_valid = st_r.ov;
  assign out_data  = st_r.od;

  always_comb
  begin
    st_nxt = st_r;
    wr     = in_valid && in_ready;
    rd     = (!st_r.ov || out_ready) && (st_r.cnt != '0);
    if (wr)
    begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (rd)
    begin
      st_nxt.od = st_r.mem[st_r.rp];
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    if (rd)
      st_nxt.ov = 1'b1;
    else if (out_ready)
      st_nxt.ov = 1'b0;
    st_nxt.cnt = st_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else if (clk_en)
      st_r <= st_nxt;
  end

endmodule : cfr_fifo

// ### src/cfr_pkg.sv
// constants and types shared by the frame readout sequencer
package cfr_pkg;

  // --------------------------------------------------------------
  // clock and vertical timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ     = 40;
  localparam int VW_MIN_NS   = 11000;
  // least time, so round up to whole cycles
  localparam int VW_CYC      = (VW_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int VCNT_W      = 9;
  localparam int PH_LAST     = 3;

  // --------------------------------------------------------------
  // frame geometry, per output
  // --------------------------------------------------------------
  localparam int DUMMY_PIX   = 20;
  localparam int DARK_PIX    = 36;
  localparam int BUF_PIX     = 20;
  localparam int BLUE_COLS   = 4;
  localparam int ACTIVE_COLS = 5270;
  localparam int ACTIVE_ROWS = 3516;
  localparam int DARK_TOP    = 30;
  localparam int DARK_BOT    = 23;
  localparam int BUF_LINES   = 20;
  localparam int PIX_PER_OUT = DUMMY_PIX + DARK_PIX + BUF_PIX
                               + ACTIVE_COLS / 2;
  localparam int LINES       = DARK_TOP + BUF_LINES + ACTIVE_ROWS
                               + BUF_LINES + DARK_BOT;
  localparam int CNT_W       = 12;
  localparam int DARK_AVG_N  = 32;
  localparam int DARK_AVG_SH = 5;

  // --------------------------------------------------------------
  // reset values and codes
  // --------------------------------------------------------------
  localparam logic [31:0] INT_RST = 32'h0000_0000;

  typedef enum logic [4:0] {
    CFR_IDLE  = 5'b00001,
    CFR_INTEG = 5'b00010,
    CFR_VXA   = 5'b00100,
    CFR_VXB   = 5'b01000,
    CFR_HREAD = 5'b10000
  } cfr_state_e;

  typedef enum logic [1:0] {
    CFR_COL_DUMMY  = 2'h0,
    CFR_COL_DARK   = 2'h1,
    CFR_COL_BUF    = 2'h2,
    CFR_COL_ACTIVE = 2'h3
  } cfr_col_e;

  typedef enum logic [1:0] {
    CFR_RED   = 2'h0,
    CFR_GR    = 2'h1,
    CFR_GB    = 2'h2,
    CFR_BLUE  = 2'h3
  } cfr_colour_e;

endpackage : cfr_pkg

// ### src/cfr_readout_ctrl.sv
// timing generator driving a dual-output full-frame sensor
`timescale 1ns/1ps

// --------------------------------------------------------------
// rule summary
// --------------------------------------------------------------
// Overview of operation
// RQ1: while integrating, both vertical phases stay low.
// RQ2: a row is moved vertically first, then its pixels shift out.
// RQ3: horizontal phase a is high while vertical phase b falls.
// RQ4: horizontal phases a and b toggle in opposition.
// RQ5: each fall of the last horizontal phase gives one sample.
// RQ6: the sense reset gate pulses after each sample is taken.
// RQ7: 20 dummy pixels lead each line and are kept out of dark level.
// RQ8: 36 dark pixels follow the dummies and give a line dark level; the code averages only the first 32 (DARK_AVG_N).
// RQ9: 30 dark lines open and 23 dark lines close every frame.
// RQ10: 20 buffer columns, first 4 blue then the colour mosaic.
// RQ11: counters cover the 5270 by 3516 active area too.
// RQ12: one integrate then readout per frame, both outputs at once.
module cfr_readout_ctrl #(
  parameter int ADC_W  = 16,
  parameter int FIFO_D = 8
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire logic               frame_start,
  input  wire logic [31:0]        int_cycles,
  input  wire logic [ADC_W-1:0]   adc_left,
  input  wire logic [ADC_W-1:0]   adc_right,
  output logic                    vert_phase_a,
  output logic                    vert_phase_b,
  output logic                    horiz_phase_a,
  output logic                    horiz_phase_b,
  output logic                    horiz_last_phase,
  output logic                    sense_reset_gate,
  output logic                    sample_strobe,
  output logic                    busy,
  output logic                    frame_done,
  output logic                    pix_valid,
  input  wire logic               pix_ready,
  output logic [2*ADC_W+4:0]      pix_data,
  output logic [ADC_W-1:0]        dark_level_left,
  output logic [ADC_W-1:0]        dark_level_right,
  output logic                    dark_level_valid
);

  localparam int DW = 2 * ADC_W + 5;

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    cfr_pkg::cfr_state_e            state;
    logic [31:0]                    int_cnt;
    logic [cfr_pkg::VCNT_W-1:0]     vcnt;
    logic [1:0]                     ph;
    logic [cfr_pkg::CNT_W-1:0]      col;
    logic [cfr_pkg::CNT_W-1:0]      line;
    logic [ADC_W-1:0]               sy1_l;
    logic [ADC_W-1:0]               sy2_l;
    logic [ADC_W-1:0]               sy1_r;
    logic [ADC_W-1:0]               sy2_r;
    logic                           v1;
    logic                           v2;
    logic                           h1;
    logic                           h2;
    logic                           h1l;
    logic                           rg;
    logic                           smp;
    logic                           busy;
    logic                           done;
  } cfr_ctrl_s;

  cfr_ctrl_s         st_r;
  cfr_ctrl_s         st_nxt;
  logic              push;
  logic              fifo_rdy;
  logic [DW-1:0]     push_data;
  logic              dark_acc;
  logic              dark_load;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic cfr_pkg::cfr_col_e col_region(
    input logic [cfr_pkg::CNT_W-1:0] c
  );
    if (c < cfr_pkg::CNT_W'(cfr_pkg::DUMMY_PIX))
      return cfr_pkg::CFR_COL_DUMMY;
    else if (c < cfr_pkg::CNT_W'(cfr_pkg::DUMMY_PIX
                                 + cfr_pkg::DARK_PIX))
      return cfr_pkg::CFR_COL_DARK;
    else if (c < cfr_pkg::CNT_W'(cfr_pkg::DUMMY_PIX
                                 + cfr_pkg::DARK_PIX
                                 + cfr_pkg::BUF_PIX))
      return cfr_pkg::CFR_COL_BUF;
    else
      return cfr_pkg::CFR_COL_ACTIVE;
  endfunction : col_region

  function automatic logic dark_line(
    input logic [cfr_pkg::CNT_W-1:0] l
  );
    return (l < cfr_pkg::CNT_W'(cfr_pkg::DARK_TOP)) ||
           (l >= cfr_pkg::CNT_W'(cfr_pkg::LINES - cfr_pkg::DARK_BOT));
  endfunction : dark_line

  function automatic cfr_pkg::cfr_colour_e colour(
    input logic [cfr_pkg::CNT_W-1:0] c,
    input logic [cfr_pkg::CNT_W-1:0] l
  );
    logic [cfr_pkg::CNT_W-1:0] first_buf;
    first_buf = cfr_pkg::CNT_W'(cfr_pkg::DUMMY_PIX + cfr_pkg::DARK_PIX);
    if (c >= first_buf &&
        c < first_buf + cfr_pkg::CNT_W'(cfr_pkg::BLUE_COLS))
      return cfr_pkg::CFR_BLUE;
    else
      return cfr_pkg::cfr_colour_e'({l[0], c[0]});
  endfunction : colour

  // --------------------------------------------------------------
  // output drivers, all flip-flops
  // --------------------------------------------------------------
  assign vert_phase_a     = st_r.v1;
  assign vert_phase_b     = st_r.v2;
  assign horiz_phase_a    = st_r.h1;
  assign horiz_phase_b    = st_r.h2;
  assign horiz_last_phase = st_r.h1l;
  assign sense_reset_gate = st_r.rg;
  assign sample_strobe    = st_r.smp;
  assign busy             = st_r.busy;
  assign frame_done       = st_r.done;

  // --------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.done  = 1'b0;
    // adc pins are held steady by the front-end around each sample,
    // so a plain two-stage sync per bit is enough here
    st_nxt.sy1_l = adc_left;
    st_nxt.sy2_l = st_r.sy1_l;
    st_nxt.sy1_r = adc_right;
    st_nxt.sy2_r = st_r.sy1_r;
    push      = 1'b0;
    dark_acc  = 1'b0;
    dark_load = 1'b0;
    push_data = {2'(colour(st_r.col, st_r.line)),
                 dark_line(st_r.line),
                 2'(col_region(st_r.col)),
                 st_r.sy2_l, st_r.sy2_r};

    case (st_r.state)
      cfr_pkg::CFR_IDLE:
      begin
        if (frame_start)
        begin
          st_nxt.int_cnt = int_cycles;
          st_nxt.state   = cfr_pkg::CFR_INTEG;  // RQ12
        end
      end
      cfr_pkg::CFR_INTEG:
      begin
        if (st_r.int_cnt == '0)
        begin
          st_nxt.line  = '0;
          st_nxt.vcnt  = '0;
          st_nxt.state = cfr_pkg::CFR_VXA;
        end
        else
          st_nxt.int_cnt = st_r.int_cnt - 32'h1;
      end
      cfr_pkg::CFR_VXA:
      begin
        if (st_r.vcnt == cfr_pkg::VCNT_W'(cfr_pkg::VW_CYC - 1))
        begin
          st_nxt.vcnt  = '0;
          st_nxt.state = cfr_pkg::CFR_VXB;
        end
        else
          st_nxt.vcnt = st_r.vcnt + 1'b1;
      end
      cfr_pkg::CFR_VXB:
      begin
        if (st_r.vcnt == cfr_pkg::VCNT_W'(cfr_pkg::VW_CYC - 1))
        begin
          st_nxt.vcnt  = '0;
          st_nxt.ph    = '0;
          st_nxt.col   = '0;
          st_nxt.state = cfr_pkg::CFR_HREAD;  // RQ2
        end
        else
          st_nxt.vcnt = st_r.vcnt + 1'b1;
      end
      cfr_pkg::CFR_HREAD:
      begin
        if (st_r.ph != 2'(cfr_pkg::PH_LAST))
          st_nxt.ph = st_r.ph + 1'b1;
        else if (fifo_rdy && !st_r.smp)
        begin
          // a full fifo freezes the pixel clocks here; ph3 lasts two cycles
          // or more so the synced adc level is the packet just dumped
          push      = 1'b1;  // RQ5 RQ12
          dark_acc  = (st_r.col >= cfr_pkg::CNT_W'(cfr_pkg::DUMMY_PIX))
                      && (st_r.col < cfr_pkg::CNT_W'(cfr_pkg::DUMMY_PIX
                                       + cfr_pkg::DARK_AVG_N));  // RQ7 RQ8
          dark_load = (st_r.col == cfr_pkg::CNT_W'(cfr_pkg::DUMMY_PIX
                                   + cfr_pkg::DARK_PIX));  // RQ8
          st_nxt.ph = '0;
          if (st_r.col == cfr_pkg::CNT_W'(cfr_pkg::PIX_PER_OUT - 1))
          begin
            st_nxt.col = '0;
            if (st_r.line == cfr_pkg::CNT_W'(cfr_pkg::LINES - 1))  // RQ9 RQ11
            begin
              st_nxt.state = cfr_pkg::CFR_IDLE;
              st_nxt.done  = 1'b1;
            end
            else
            begin
              st_nxt.line  = st_r.line + 1'b1;
              st_nxt.state = cfr_pkg::CFR_VXA;
            end
          end
          else
            st_nxt.col = st_r.col + 1'b1;  // RQ10 RQ11
        end
      end
      default:
        st_nxt.state = cfr_pkg::CFR_IDLE;
    endcase

    // phase levels follow the next state so the pins are registered
    st_nxt.v1   = (st_nxt.state == cfr_pkg::CFR_VXA);  // RQ1
    st_nxt.v2   = (st_nxt.state == cfr_pkg::CFR_VXB);  // RQ1
    st_nxt.busy = (st_nxt.state != cfr_pkg::CFR_IDLE);
    st_nxt.smp  = (st_nxt.state == cfr_pkg::CFR_HREAD) &&
                  (st_nxt.ph == 2'(cfr_pkg::PH_LAST)) &&
                  (st_r.ph != 2'(cfr_pkg::PH_LAST));
    if (st_nxt.state == cfr_pkg::CFR_HREAD)
    begin
      st_nxt.h1  = (st_nxt.ph < 2'h2);  // RQ3 RQ4
      st_nxt.h2  = (st_nxt.ph >= 2'h2);  // RQ4
      st_nxt.h1l = (st_nxt.ph < 2'h2);  // RQ5
      // reset pulse only after the previous sample has been taken
      st_nxt.rg  = (st_nxt.ph == 2'h0) && (st_r.ph != 2'h0);  // RQ6
    end
    else
    begin
      // phase a held high across the vertical transfer
      st_nxt.h1  = (st_nxt.state == cfr_pkg::CFR_VXA) ||
                   (st_nxt.state == cfr_pkg::CFR_VXB);  // RQ3
      st_nxt.h2  = 1'b0;
      st_nxt.h1l = st_nxt.h1;
      // the last sample of a line needs its reset pulse as well
      st_nxt.rg  = push;  // RQ6
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r         <= '0;
      st_r.state   <= cfr_pkg::CFR_IDLE;
      st_r.int_cnt <= cfr_pkg::INT_RST;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------
  // data path
  // --------------------------------------------------------------
  cfr_fifo #(
    .W     (DW),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .in_data   (push_data),
    .out_valid (pix_valid),
    .out_ready (pix_ready),
    .out_data  (pix_data)
  );

  cfr_dark_ref #(
    .W (ADC_W)
  ) u_dark_l (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .acc_en      (dark_acc),
    .load        (dark_load),
    .sample      (st_r.sy2_l),
    .level       (dark_level_left),
    .level_valid (dark_level_valid)
  );

  cfr_dark_ref #(
    .W (ADC_W)
  ) u_dark_r (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .acc_en      (dark_acc),
    .load        (dark_load),
    .sample      (st_r.sy2_r),
    .level       (dark_level_right),
    .level_valid ()
  );

endmodule : cfr_readout_ctrl

// ### verif/cfr_readout_ctrl_monitor.sv
// assertion checker on the readout sequencer pins
`timescale 1ns/1ps
module cfr_readout_ctrl_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        frame_start,
  input wire logic [31:0] int_cycles,
  input wire logic        vert_phase_a,
  input wire logic        vert_phase_b,
  input wire logic        horiz_phase_a,
  input wire logic        horiz_phase_b,
  input wire logic        horiz_last_phase,
  input wire logic        sense_reset_gate,
  input wire logic        sample_strobe,
  input wire logic        busy,
  input wire logic        frame_done
);
  logic [9:0] v_cnt_r;
  logic       smp_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  // frozen edges are skipped, the sequencer holds its pins then
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      v_cnt_r <= '0;
      smp_r   <= 1'b0;
    end
    else if (clk_en)
    begin
      v_cnt_r <= (vert_phase_a || vert_phase_b) ? v_cnt_r + 10'h001 : '0;
      smp_r   <= sample_strobe || (smp_r && !sense_reset_gate);
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_start_busy: assert property (
    clk_en && !busy && frame_start |=> busy)
    else $error("busy missing after frame start");
  a_integ_low: assert property (
    clk_en && !busy && frame_start && int_cycles != 32'h0 |=>
    (!vert_phase_a && !vert_phase_b)[*2])
    else $error("vertical phase moved while integrating");
  a_vert_order: assert property (
    $fell(vert_phase_a) |-> vert_phase_b && horiz_phase_a &&
    v_cnt_r == 10'(cfr_pkg::VW_CYC))
    else $error("first vertical phase ended wrongly");
  a_row_load: assert property (
    $fell(vert_phase_b) |-> horiz_phase_a &&
    v_cnt_r == 10'(2 * cfr_pkg::VW_CYC))
    else $error("row load without first horizontal phase high");
  a_horiz_compl: assert property (
    busy && !vert_phase_a && !vert_phase_b &&
    (horiz_phase_a || horiz_phase_b) |-> horiz_phase_a != horiz_phase_b)
    else $error("horizontal phases not complementary");
  a_strobe_dump: assert property (
    sample_strobe |-> horiz_phase_b && !horiz_last_phase)
    else $error("sample taken before charge dump");
  a_dump_strobe: assert property (
    $fell(horiz_last_phase) |-> ##[1:1000] sample_strobe)
    else $error("charge dump never sampled");
  a_rg_after_smp: assert property (
    sense_reset_gate |-> smp_r && !sample_strobe)
    else $error("reset gate pulsed before sampling");
  a_rg_pulse: assert property (
    clk_en && sense_reset_gate |=> !sense_reset_gate)
    else $error("reset gate pulse too long");
  a_en_freeze: assert property (
    !clk_en |=> $stable({vert_phase_a, vert_phase_b, horiz_phase_a,
                         horiz_phase_b, horiz_last_phase, busy}))
    else $error("pins moved while clock enable low");
  a_done_idle: assert property (
    busy |-> !frame_done)
    else $error("frame done raised while still busy");
endmodule : cfr_readout_ctrl_monitor

// ### verif/cfr_readout_ctrl_tb.sv
// self-checking bench for the frame readout sequencer
`timescale 1ns/1ps
module cfr_readout_ctrl_tb;
  localparam int FIFO_D  = 8;
  localparam int CYC_MAX = 20000;

  logic        clk;
  logic        sys_rst;
  logic        clk_en;
  logic        frame_start;
  logic [31:0] int_cycles;
  logic [15:0] adc_left;
  logic [15:0] adc_right;
  logic        vert_phase_a;
  logic        vert_phase_b;
  logic        horiz_phase_a;
  logic        horiz_phase_b;
  logic        horiz_last_phase;
  logic        sense_reset_gate;
  logic        sample_strobe;
  logic        busy;
  logic        frame_done;
  logic        pix_valid;
  logic        pix_ready;
  logic [36:0] pix_data;
  logic [15:0] dark_level_left;
  logic [15:0] dark_level_right;
  logic        dark_level_valid;
  logic [15:0] seed;
  logic        rdy_on;
  logic [31:0] xs = 32'he2a8a423;
  int          error_cnt = 0;
  int          checked = 0;
  int          rx_n, dk_n, st_n, cyc, ic, exp_row;

  cfr_readout_ctrl #(.ADC_W(16), .FIFO_D(FIFO_D)) cfr_readout_ctrl_i (
    .clk, .sys_rst, .clk_en, .frame_start, .int_cycles, .adc_left,
    .adc_right, .vert_phase_a, .vert_phase_b, .horiz_phase_a,
    .horiz_phase_b, .horiz_last_phase, .sense_reset_gate, .sample_strobe,
    .busy, .frame_done, .pix_valid, .pix_ready, .pix_data,
    .dark_level_left, .dark_level_right, .dark_level_valid);

  cfr_sensor_model cfr_sensor_model_i (
    .vert_phase_b, .horiz_phase_a, .horiz_last_phase, .sense_reset_gate,
    .seed, .adc_left, .adc_right);

  // --------------------------------------------------------------
  // reference model
  // --------------------------------------------------------------
  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction : rnd

  function automatic logic [15:0] pix(int r, int c, logic [15:0] s);
    return {r[7:0] ^ s[15:8], c[7:0] ^ s[7:0]};
  endfunction : pix

  // first line only: dark line, even line for the colour mosaic
  function automatic logic [36:0] exp_word(int k);
    logic [1:0] rg;
    logic [1:0] cl;
    rg = k < 20 ? 2'h0 : k < 56 ? 2'h1 : k < 76 ? 2'h2 : 2'h3;
    cl = (k >= 56 && k < 60) ? 2'h3 : {1'b0, k[0]};
    return {cl, 1'b1, rg, pix(exp_row, k, seed), pix(k, exp_row, ~seed)};
  endfunction : exp_word

  function automatic logic [36:0] dark_exp();
    int sl;
    int sr;
    sl = 0;
    sr = 0;
    for (int c = 20; c < 52; c++)
    begin
      sl += pix(exp_row, c, seed);
      sr += pix(c, exp_row, ~seed);
    end
    return {5'h00, 16'(sl >> 5), 16'(sr >> 5)};
  endfunction : dark_exp

  task chk(logic [36:0] seen, logic [36:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // starts a frame and measures the integration length
  task start();
    int n;
    ic = 1 + rnd() % 8;
    seed <= 16'(rnd());
    int_cycles <= 32'(ic);
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (vert_phase_a !== 1'b1 && n < 100);
    chk(37'(n), 37'(ic + 1));
  endtask : start

  // --------------------------------------------------------------
  // clock, watchdog, sink
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == CYC_MAX)
    begin
      error_cnt++;
      end_sim();
    end
  end

  always @(posedge clk)
  begin
    if (!sys_rst && clk_en && pix_valid === 1'b1 && pix_ready)
    begin
      chk(pix_data, exp_word(rx_n));
      rx_n++;
    end
    if (!sys_rst && clk_en && dark_level_valid === 1'b1)
    begin
      chk({5'h00, dark_level_left, dark_level_right}, dark_exp());
      dk_n++;
    end
    if (sample_strobe === 1'b1 && clk_en)
      st_n++;
    pix_ready <= rdy_on && (rnd() % 4 != 0);
  end

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    frame_start = 1'b0;
    int_cycles = 32'h0;
    pix_ready = 1'b0;
    seed = 16'h0;
    rdy_on = 1'b0;
    {rx_n, dk_n, st_n, cyc} = '0;
    exp_row = 1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({26'h0, frame_done, horiz_phase_b, sense_reset_gate,
         dark_level_valid, busy, vert_phase_a, vert_phase_b,
         horiz_phase_a, horiz_last_phase, pix_valid,
         sample_strobe}, 37'h0);
    $display("test reset done");
    start();
    // a start while busy must not restart the vertical transfer
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    repeat (20) @(posedge clk);
    clk_en <= 1'b0;
    repeat (1 + rnd() % 8) @(posedge clk);
    clk_en <= 1'b1;
    rdy_on <= 1'b1;
    wait (rx_n >= 60);
    @(posedge clk);
    #1;
    chk(37'(dk_n), 37'h1);
    $display("test frame_a done");
    sys_rst <= 1'b1;
    rdy_on <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({36'h0, busy}, 37'h0);
    {rx_n, dk_n, st_n} = '0;
    exp_row = 2;
    sys_rst <= 1'b0;
    @(posedge clk);
    start();
    while (vert_phase_b !== 1'b1) @(posedge clk);
    while (vert_phase_b === 1'b1) @(posedge clk);
    repeat (150) @(posedge clk);
    #1;
    // nine words fit, the tenth pixel is strobed and then held at ph3
    chk(37'(st_n), 37'(FIFO_D + 2));
    chk({36'h0, pix_valid}, 37'h1);
    rdy_on <= 1'b1;
    wait (rx_n >= 30);
    $display("test stall_b done");
    end_sim();
  end
endmodule : cfr_readout_ctrl_tb

bind cfr_readout_ctrl cfr_readout_ctrl_monitor mon_i (
  .clk, .sys_rst, .clk_en, .frame_start, .int_cycles, .vert_phase_a,
  .vert_phase_b, .horiz_phase_a, .horiz_phase_b, .horiz_last_phase,
  .sense_reset_gate, .sample_strobe, .busy, .frame_done);

// ### verif/cfr_sensor_model.sv
// behavioural dual-output sensor answering the phase pins
`timescale 1ns/1ps
module cfr_sensor_model #(
  parameter logic [15:0] RST_LVL = 16'hfff0
) (
  input  wire logic        vert_phase_b,
  input  wire logic        horiz_phase_a,
  input  wire logic        horiz_last_phase,
  input  wire logic        sense_reset_gate,
  input  wire logic [15:0] seed,
  output logic      [15:0] adc_left,
  output logic      [15:0] adc_right
);
  int row = 0;
  int col = 0;

  function automatic logic [15:0] pix(int r, int c, logic [15:0] s);
    return {r[7:0] ^ s[15:8], c[7:0] ^ s[7:0]};
  endfunction : pix

  initial
  begin
    adc_left  = RST_LVL;
    adc_right = RST_LVL;
  end

  // rows move only here, so steady low phases keep the image in place
  always @(negedge vert_phase_b)
    if (horiz_phase_a === 1'b1)
    begin
      row++;
      col = 0;
    end

  // index runs through dummy, dark, buffer and active columns alike
  always @(negedge horiz_last_phase)
  begin
    adc_left  = pix(row, col, seed);
    adc_right = pix(col, row, ~seed);
    col++;
  end

  // node shows the drain level until the next dump
  always @(posedge sense_reset_gate)
  begin
    adc_left  = RST_LVL;
    adc_right = RST_LVL;
  end
endmodule : cfr_sensor_model
